// *** rtl/pmwc_pkg.sv ***
// Package of constants and types for the power mode wake-up control block.
package pmwc_pkg;

  // ----------------------------------------------------------------------
  // Clock select encodings, port and interrupt widths
  // ----------------------------------------------------------------------
  localparam logic [2:0] CKS_SUB       = 3'h7;
  localparam logic [2:0] CKS_RESET     = 3'h0;
  localparam int         PORT_A_WIDTH  = 8;
  localparam int         NUM_IRQ       = 8;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 5;
  // Low-speed RC clock taken as 32 kHz, period 31250 ns.
  localparam int LOW_SPEED_RC_OSC_PERIOD_NS   = 31250;
  localparam int LOW_SPEED_RC_OSC_DIV_CYCLES  = LOW_SPEED_RC_OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int WDT_CNT_WIDTH    = 18;
  localparam int HS_STABLE_CYCLES = 64;

  typedef enum logic [2:0] {
    PMWC_RUN,
    PMWC_SLEEP,
    PMWC_IDLE_LOW_CLOCK_MODE,
    PMWC_IDLE_BOTH_CLOCKS_MODE,
    PMWC_IDLE_HIGH_CLOCK_MODE,
    PMWC_WAKE
  } pmwc_state_type;

endpackage : pmwc_pkg

// *** rtl/pmwc_top.sv ***
// Power-mode sequencer: clock select, halt modes, wake-up, watchdog.
// How it works
// - Select 0..6 runs high clock divided 1..64.
// - Stable flag reports high oscillator restart.
// - Halt with keepalives 00 enters sleep.
// - Low-power modes stall CPU, hold state.
// - Entry sets power-down, clears timeout flag.
// - Entry clears watchdog, which keeps counting.
// - Keepalives hs0 ls1 give idle_low_clock_mode.
// - Keepalives both one give idle_both_clocks_mode.
// - Keepalives hs1 ls0 give idle_high_clock_mode.
// - Reset pin, port A, interrupt, watchdog wake.
// - Power-down clears only on power-up, clear.
// - Reset pin wake does full reset.
// - Watchdog wake sets timeout, resets PC/SP.
// - Enabled port A falling edge wakes, resumes.
// - Disabled or stack-full interrupt resumes, stays pending.
// - Enabled interrupt with stack room is serviced.
// - Flag already set at entry cannot wake.
// - Wake waits for oscillator stabilisation, except with select 7 or reset pin.
// - Watchdog divides RC clock 2^8 to 2^18.
// - Select 7 runs from sub clock.
module pmwc_top (
  // Clock and reset
  input  wire logic                              core_clk,
  input  wire logic                              rst,
  // CPU side
  input  wire logic                              halt_exec,
  input  wire logic                              clr_wdt_exec,
  input  wire logic                              stack_full,
  output logic                                   cpu_stall,
  output logic                                   pc_sp_reset,
  output logic                                   irq_service,
  // Control bits
  input  wire logic [2:0]                        sys_clk_select,
  input  wire logic                              hs_osc_keepalive_enable,
  input  wire logic                              ls_osc_keepalive_enable,
  input  wire logic                              hs_osc_enable,
  input  wire logic [2:0]                        wdt_period_select,
  // Wake sources
  input  wire logic                              ext_reset_pin,
  input  wire logic [pmwc_pkg::PORT_A_WIDTH-1:0] port_a_pins,
  input  wire logic [pmwc_pkg::PORT_A_WIDTH-1:0] port_a_wake_enable,
  input  wire logic [pmwc_pkg::NUM_IRQ-1:0]      irq_req,
  input  wire logic [pmwc_pkg::NUM_IRQ-1:0]      irq_enable,
  // Clock gating and status
  output logic                                   sys_clk_en,
  output logic                                   hs_clk_run,
  output logic                                   sub_clk_run,
  output logic                                   low_rc_clock,
  output logic                                   hs_osc_stable_flag,
  output logic                                   power_down_flag,
  output logic                                   watchdog_timeout_flag,
  output logic                                   full_reset,
  output logic                                   wdt_overflow
);

  // ----------------------------------------------------------------------
  // State and registers
  // ----------------------------------------------------------------------
  pmwc_pkg::pmwc_state_type state_r, state_nxt;
  logic [12:0] low_speed_rc_osc_cnt_r, low_speed_rc_osc_cnt_nxt;
  logic [pmwc_pkg::WDT_CNT_WIDTH-1:0] wdt_cnt_r, wdt_cnt_nxt;
  logic [6:0] div_cnt_r, div_cnt_nxt;
  logic [6:0] stab_cnt_r, stab_cnt_nxt;
  logic [pmwc_pkg::PORT_A_WIDTH-1:0] pa_prev_r, pa_prev_nxt;
  logic [pmwc_pkg::NUM_IRQ-1:0] irq_mask_r, irq_mask_nxt;
  logic pdf_r, pdf_nxt, to_r, to_nxt, low_speed_rc_osc_r, low_speed_rc_osc_nxt;
  logic pcsp_r, pcsp_nxt, svc_r, svc_nxt, frst_r, frst_nxt;
  logic ovf_r, ovf_nxt;

  logic low_speed_rc_osc_tick, wdt_ovf, hs_run, pa_wake;
  logic [pmwc_pkg::NUM_IRQ-1:0] irq_wake;
  logic [6:0] div_limit;

  // ----------------------------------------------------------------------
  // Combinational decode
  // ----------------------------------------------------------------------
  always_comb begin
    // Oscillator runs in wake, idle_both_clocks_mode, idle_high_clock_mode, and in run unless select 7 with enable off.
    hs_run = (state_r == pmwc_pkg::PMWC_RUN && (hs_osc_enable ||
              sys_clk_select != pmwc_pkg::CKS_SUB))
             || state_r == pmwc_pkg::PMWC_WAKE
             || state_r == pmwc_pkg::PMWC_IDLE_BOTH_CLOCKS_MODE
             || state_r == pmwc_pkg::PMWC_IDLE_HIGH_CLOCK_MODE;
    // Divider limit 2^n - 1 for select n.
    div_limit = 7'((8'h01 << sys_clk_select) - 8'h01);
    low_speed_rc_osc_tick = (low_speed_rc_osc_cnt_r == 13'(pmwc_pkg::LOW_SPEED_RC_OSC_DIV_CYCLES - 1));
    unique case (wdt_period_select)
      3'h0:    wdt_ovf = wdt_cnt_r[7:0] == 8'hff;
      3'h1:    wdt_ovf = wdt_cnt_r[9:0] == 10'h3ff;
      3'h2:    wdt_ovf = wdt_cnt_r[11:0] == 12'hfff;
      3'h3:    wdt_ovf = wdt_cnt_r[13:0] == 14'h3fff;
      3'h4:    wdt_ovf = wdt_cnt_r[14:0] == 15'h7fff;
      3'h5:    wdt_ovf = wdt_cnt_r[15:0] == 16'hffff;
      3'h6:    wdt_ovf = wdt_cnt_r[16:0] == 17'h1ffff;
      default: wdt_ovf = wdt_cnt_r == 18'h3ffff;
    endcase
    wdt_ovf = wdt_ovf && low_speed_rc_osc_tick;
    pa_wake = |(pa_prev_r & ~port_a_pins & port_a_wake_enable);
    // Only requests that rose after entry may wake.
    irq_wake = irq_req & ~irq_mask_r;
  end

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    state_nxt    = state_r;
    low_speed_rc_osc_cnt_nxt = low_speed_rc_osc_tick ? 13'h0000 : low_speed_rc_osc_cnt_r + 13'h0001;
    low_speed_rc_osc_nxt     = low_speed_rc_osc_tick ? ~low_speed_rc_osc_r : low_speed_rc_osc_r;
    wdt_cnt_nxt  = wdt_cnt_r;
    div_cnt_nxt  = div_cnt_r;
    stab_cnt_nxt = stab_cnt_r;
    pa_prev_nxt  = port_a_pins;
    irq_mask_nxt = irq_mask_r;
    pdf_nxt      = pdf_r;
    to_nxt       = to_r;
    pcsp_nxt     = 1'b0;
    svc_nxt      = 1'b0;
    frst_nxt     = 1'b0;
    ovf_nxt      = wdt_ovf;
    // Watchdog always counts; the low-speed clock never stops.
    if (low_speed_rc_osc_tick) begin
      wdt_cnt_nxt = wdt_ovf ? '0 : wdt_cnt_r + 1'b1;
    end
    if (clr_wdt_exec && state_r == pmwc_pkg::PMWC_RUN) begin
      wdt_cnt_nxt = '0;
      pdf_nxt     = 1'b0;
      to_nxt      = 1'b0;
    end
    // Stabilisation restarts whenever the oscillator is off.
    if (!hs_run) begin
      stab_cnt_nxt = '0;
    end else if (stab_cnt_r != 7'(pmwc_pkg::HS_STABLE_CYCLES)) begin
      stab_cnt_nxt = stab_cnt_r + 7'h01;
    end
    if (state_r == pmwc_pkg::PMWC_RUN
        && sys_clk_select != pmwc_pkg::CKS_SUB) begin
      div_cnt_nxt = (div_cnt_r >= div_limit) ? 7'h00
                    : div_cnt_r + 7'h01;
    end
    unique case (state_r)
      pmwc_pkg::PMWC_RUN: begin
        if (halt_exec) begin
          // Keep-alive bits sampled on the halt itself.
          unique case ({hs_osc_keepalive_enable,
                        ls_osc_keepalive_enable})
            2'b00: state_nxt = pmwc_pkg::PMWC_SLEEP;
            2'b01: state_nxt = pmwc_pkg::PMWC_IDLE_LOW_CLOCK_MODE;
            2'b11: state_nxt = pmwc_pkg::PMWC_IDLE_BOTH_CLOCKS_MODE;
            2'b10: state_nxt = pmwc_pkg::PMWC_IDLE_HIGH_CLOCK_MODE;
          endcase
          pdf_nxt      = 1'b1;
          to_nxt       = 1'b0;
          wdt_cnt_nxt  = '0;
          low_speed_rc_osc_cnt_nxt = '0;
          irq_mask_nxt = irq_req;
        end
      end
      pmwc_pkg::PMWC_WAKE: begin
        if (stab_cnt_r == 7'(pmwc_pkg::HS_STABLE_CYCLES)
            || sys_clk_select == pmwc_pkg::CKS_SUB) begin
          state_nxt = pmwc_pkg::PMWC_RUN;
          svc_nxt   = |(irq_wake & irq_enable) && !stack_full;
        end
      end
      default: begin
        if (wdt_ovf) begin
          to_nxt    = 1'b1;
          pcsp_nxt  = 1'b1;
          state_nxt = pmwc_pkg::PMWC_WAKE;
        end else if (pa_wake || |irq_wake) begin
          state_nxt = pmwc_pkg::PMWC_WAKE;
        end
      end
    endcase
    // Normal-run overflow resets the device and also marks timeout.
    if (wdt_ovf && state_r == pmwc_pkg::PMWC_RUN) begin
      to_nxt   = 1'b1;
      frst_nxt = 1'b1;
    end
    if (ext_reset_pin) begin
      state_nxt = pmwc_pkg::PMWC_RUN;
      frst_nxt  = 1'b1;
      wdt_cnt_nxt = '0;
    end
  end

  // ----------------------------------------------------------------------
  // Mode registers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r    <= pmwc_pkg::PMWC_RUN;
      irq_mask_r <= '0;
    end else begin
      state_r    <= state_nxt;
      irq_mask_r <= irq_mask_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Low-speed clock registers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      low_speed_rc_osc_cnt_r <= '0;
      low_speed_rc_osc_r     <= 1'b0;
    end else begin
      low_speed_rc_osc_cnt_r <= low_speed_rc_osc_cnt_nxt;
      low_speed_rc_osc_r     <= low_speed_rc_osc_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Watchdog registers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wdt_cnt_r <= '0;
      ovf_r     <= 1'b0;
    end else begin
      wdt_cnt_r <= wdt_cnt_nxt;
      ovf_r     <= ovf_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Divider and stabilisation registers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_cnt_r  <= '0;
      stab_cnt_r <= '0;
    end else begin
      div_cnt_r  <= div_cnt_nxt;
      stab_cnt_r <= stab_cnt_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Wake pin history
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pa_prev_r <= '0;
    end else begin
      pa_prev_r <= pa_prev_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pdf_r <= 1'b0;
      to_r  <= 1'b0;
    end else begin
      pdf_r <= pdf_nxt;
      to_r  <= to_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Event pulses
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pcsp_r <= 1'b0;
      svc_r  <= 1'b0;
      frst_r <= 1'b0;
    end else begin
      pcsp_r <= pcsp_nxt;
      svc_r  <= svc_nxt;
      frst_r <= frst_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Sub-clock mode enables the CPU on each low-speed tick.
  assign sys_clk_en  = (state_r == pmwc_pkg::PMWC_RUN)
                       && ((sys_clk_select == pmwc_pkg::CKS_SUB) ? low_speed_rc_osc_tick
                           : div_cnt_r == 7'h00);
  assign cpu_stall   = state_r != pmwc_pkg::PMWC_RUN;
  assign hs_clk_run  = hs_run;
  // Mode state, not the live bit, so later writes cannot move the clock.
  assign sub_clk_run = (state_r != pmwc_pkg::PMWC_SLEEP)
                       && (state_r != pmwc_pkg::PMWC_IDLE_HIGH_CLOCK_MODE);
  assign low_rc_clock = low_speed_rc_osc_r;
  assign hs_osc_stable_flag = stab_cnt_r
                              == 7'(pmwc_pkg::HS_STABLE_CYCLES);
  assign power_down_flag       = pdf_r;
  assign watchdog_timeout_flag = to_r;
  assign pc_sp_reset = pcsp_r;
  assign irq_service = svc_r;
  assign full_reset  = frst_r;
  assign wdt_overflow = ovf_r;

endmodule : pmwc_top

// *** test/pmwc_chk_props.sv ***
// Concurrent checks of the power mode wake-up control block.
module pmwc_chk (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // Requests and controls
  input wire logic       halt_exec,
  input wire logic       clr_wdt_exec,
  input wire logic       hs_osc_keepalive_enable,
  input wire logic       ls_osc_keepalive_enable,
  input wire logic       ext_reset_pin,
  input wire logic [2:0] sys_clk_select,
  input wire logic [7:0] port_a_pins,
  input wire logic [7:0] port_a_wake_enable,
  // Status
  input wire logic       cpu_stall,
  input wire logic       sys_clk_en,
  input wire logic       hs_clk_run,
  input wire logic       sub_clk_run,
  input wire logic       hs_osc_stable_flag,
  input wire logic       power_down_flag,
  input wire logic       watchdog_timeout_flag,
  input wire logic       full_reset
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  logic run_halt;
  // A halt is only taken while running, so a stalled core cannot re-enter.
  assign run_halt = halt_exec && !cpu_stall && !ext_reset_pin;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  property p_entry;
    run_halt |=> cpu_stall && power_down_flag && !watchdog_timeout_flag;
  endproperty
  a_entry: assert property (p_entry) else $error("bad halt entry");
  property p_mode;
    run_halt |=> hs_clk_run == $past(hs_osc_keepalive_enable)
      && sub_clk_run == $past(ls_osc_keepalive_enable);
  endproperty
  a_mode: assert property (p_mode) else $error("bad mode");
  property p_noclk;
    cpu_stall |-> !sys_clk_en;
  endproperty
  a_noclk: assert property (p_noclk) else $error("clock while stalled");
  property p_pdf_set;
    $rose(power_down_flag) |-> $past(run_halt);
  endproperty
  a_pdf_set: assert property (p_pdf_set) else $error("flag set");
  property p_pdf_clr;
    $fell(power_down_flag) |-> $past(clr_wdt_exec && !cpu_stall)
      || $past(ext_reset_pin);
  endproperty
  a_pdf_clr: assert property (p_pdf_clr) else $error("flag cleared");
  property p_stable;
    $fell(cpu_stall) && sys_clk_select != 3'h7 |-> hs_osc_stable_flag;
  endproperty
  a_stable: assert property (p_stable) else $error("early resume");
  property p_pin_wake;
    cpu_stall && !ext_reset_pin
      && |(port_a_wake_enable & $past(port_a_pins) & ~port_a_pins)
      |-> ##[1:200] !cpu_stall;
  endproperty
  a_pin_wake: assert property (p_pin_wake) else $error("no wake");
  property p_rst_wake;
    $rose(ext_reset_pin) && cpu_stall |-> ##[1:4] full_reset;
  endproperty
  a_rst_wake: assert property (p_rst_wake) else $error("no reset");
  c_sleep: cover property (run_halt && !hs_osc_keepalive_enable);
  c_wake: cover property ($fell(cpu_stall));
  c_reset: cover property (full_reset);
endmodule : pmwc_chk

bind pmwc_top pmwc_chk u_pmwc_chk (.*);

// *** test/pmwc_cpu_model.sv ***
// Model of the CPU core issuing halt and clear-watchdog instructions.
module pmwc_cpu_model (
  // Clock
  input  wire logic core_clk,
  // Requests from the bench
  input  wire logic halt_req,
  input  wire logic clr_req,
  // Device side
  input  wire logic cpu_stall,
  input  wire logic hs_osc_stable_flag,
  output logic      halt_exec,
  output logic      clr_wdt_exec
);
  timeunit 1ns;
  timeprecision 1ps;
  logic go;
  // Code waits for the stable flag under every clock select, select 7 included; a stalled core runs nothing.
  assign go = !cpu_stall && hs_osc_stable_flag;
  initial begin
    halt_exec = 1'b0;
    clr_wdt_exec = 1'b0;
  end
  always @(negedge core_clk) begin
    halt_exec <= halt_req && go && !halt_exec;
    clr_wdt_exec <= clr_req && go && !clr_wdt_exec;
  end
endmodule : pmwc_cpu_model

// *** test/tb.sv ***
// Self-checking bench of the power mode wake-up control block.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Stimulus and checks
  // ------------------------------------------------------------
  logic       core_clk = 1'b0, rst = 1'b1, halt_req = 1'b0, clr_req = 1'b0;
  logic       hs_osc_keepalive_enable = 1'b0, ls_osc_keepalive_enable = 1'b0;
  logic       hs_osc_enable = 1'b1, ext_reset_pin = 1'b0, stack_full = 1'b0;
  logic [2:0] sys_clk_select = 3'h0;
  logic [7:0] port_a_pins = 8'hff, port_a_wake_enable = 8'h01;
  logic [7:0] irq_req = 8'h00, irq_enable = 8'h02;
  logic       halt_exec, clr_wdt_exec, cpu_stall, irq_service, sys_clk_en;
  logic       hs_clk_run, sub_clk_run, hs_osc_stable_flag, power_down_flag;
  logic       watchdog_timeout_flag, full_reset;
  logic       pc_sp_reset, low_rc_clock, wdt_overflow, lrc_v;
  logic [2:0] wdt_period_select = 3'h0;
  int         bad_count = 0, compares = 0, en_cnt = 0, svc_cnt = 0;
  int         rst_cnt = 0, s0, n;
  pmwc_top u_pmwc_top (.*);
  pmwc_cpu_model u_pmwc_cpu_model (.*);
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    en_cnt += (sys_clk_en === 1'b1);
    svc_cnt += (irq_service === 1'b1);
    rst_cnt += (full_reset === 1'b1);
  end
  task automatic chk(input string what, input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk);
  endtask : cyc
  task automatic halt(input logic h, l);
    hs_osc_keepalive_enable = h;
    ls_osc_keepalive_enable = l;
    halt_req = 1'b1;
    for (n = 0; n < 300 && cpu_stall !== 1'b1; n++) cyc(1);
    halt_req = 1'b0;
  endtask : halt
  task automatic wait_run();
    for (n = 0; n < 300 && cpu_stall !== 1'b0; n++) cyc(1);
    chk("cpu_stall", cpu_stall, 0);
  endtask : wait_run
  task automatic end_sim();
    if (bad_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim
  initial begin
    #100us;
    bad_count++;
    end_sim();
  end
  initial begin
    cyc(5);
    rst = 1'b0;
    chk("power_down_flag", power_down_flag, 0);
    // Slow mode with the fast oscillator stopped, then back to fast.
    sys_clk_select = 3'h7;
    hs_osc_enable = 1'b0;
    cyc(20);
    chk("hs_osc_stable_flag", hs_osc_stable_flag, 0);
    hs_osc_enable = 1'b1;
    for (int d = 0; d < 7; d++) begin
      sys_clk_select = 3'h7;
      cyc(4);
      sys_clk_select = d[2:0];
      for (n = 0; n < 300 && hs_osc_stable_flag !== 1'b1; n++) cyc(1);
      chk("hs_osc_stable_flag", hs_osc_stable_flag, 1);
      cyc(4);
      s0 = en_cnt;
      cyc(128);
      chk("sys_clk_en count", 8'(en_cnt - s0), 8'(128 >> d));
    end
    // The hs keep-alive bit is changed after the halt to prove it was latched.
    for (int m = 0; m < 4; m++) begin
      halt(m[1], m[0]);
      hs_osc_keepalive_enable = ~m[1];
      cyc(1);
      chk("power_down_flag", power_down_flag, 1);
      chk("timeout flag", watchdog_timeout_flag, 0);
      chk("sys_clk_en", sys_clk_en, 0);
      chk("hs_clk_run", hs_clk_run, m[1]);
      chk("sub_clk_run", sub_clk_run, m[0]);
      port_a_pins = 8'hfd;
      cyc(20);
      chk("cpu_stall", cpu_stall, 1);
      port_a_pins = 8'hfc;
      wait_run();
      chk("hs_osc_stable_flag", hs_osc_stable_flag, 1);
      chk("power_down_flag", power_down_flag, 1);
      port_a_pins = 8'hff;
    end
    clr_req = 1'b1;
    cyc(3);
    clr_req = 1'b0;
    cyc(2);
    chk("power_down_flag", power_down_flag, 0);
    // A request pending before the halt must not wake; a new one must.
    irq_req = 8'h01;
    cyc(2);
    halt(0, 0);
    cyc(20);
    chk("cpu_stall", cpu_stall, 1);
    s0 = svc_cnt;
    irq_req = 8'h03;
    wait_run();
    cyc(4);
    chk("irq_service count", 8'(svc_cnt - s0), 1);
    for (int k = 0; k < 2; k++) begin
      irq_req = 8'h00;
      stack_full = k[0];
      cyc(2);
      halt(1, 0);
      s0 = svc_cnt;
      irq_req = k ? 8'h02 : 8'h04;
      wait_run();
      cyc(4);
      chk("irq_service count", 8'(svc_cnt - s0), 0);
    end
    halt(1, 1);
    s0 = rst_cnt;
    ext_reset_pin = 1'b1;
    cyc(6);
    chk("full_reset seen", 8'(rst_cnt > s0), 1);
    ext_reset_pin = 1'b0;
    wait_run();
    // Longest period: no overflow may occur within one low-speed tick.
    wdt_period_select = 3'h7;
    lrc_v = low_rc_clock;
    cyc(6250);
    chk("low_rc_clock", low_rc_clock, !lrc_v);
    chk("wdt_overflow", wdt_overflow, 0);
    chk("pc_sp_reset", pc_sp_reset, 0);
    chk("timeout flag", watchdog_timeout_flag, 0);
    end_sim();
  end
endmodule : tb
